// ===== rtc_bus_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// strobe bus checker
// ----------------------------------------------------------------
module rtc_bus_asserts (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_power_fail,
    input  wire logic [18:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        dq_host_oe,
    input  wire logic [7:0]  dq_dev,
    input  wire logic        dq_dev_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // device drives only in a selected read
    a_drive_only_read: assert property (dq_dev_oe |-> !ce_n && !oe_n && we_n)
        else $error("device drives outside a read");
    a_read_drives: assert property (!ce_n && !oe_n && we_n && !i_power_fail |-> dq_dev_oe)
        else $error("selected read not driven");
    a_fail_quiet: assert property (i_power_fail |-> !dq_dev_oe)
        else $error("device drives during power fail");
    a_no_contend: assert property (!(dq_dev_oe && dq_host_oe))
        else $error("both ends drive data");
    // write cycle keeps address stable and host drives data; chip enable released within 12 cycles of falling
    a_wr_addr_hold: assert property ((!ce_n && !we_n) ##1 (!ce_n && !we_n) |-> $stable(addr))
        else $error("address moved in write");
    a_wr_data_on: assert property (!ce_n && !we_n |-> dq_host_oe)
        else $error("write without data");
    a_strobe_ends: assert property ($fell(ce_n) |-> ##[1:12] ce_n)
        else $error("strobe never released");
    // settled read shows a decimal units digit
    a_bcd_units: assert property (($stable(addr) && !ce_n && !oe_n && we_n && !i_power_fail)[*4]
        |-> dq_dev[3:0] <= 4'h9)
        else $error("units digit not decimal");

    c_write: cover property (!ce_n && !we_n);
    c_read: cover property (dq_dev_oe);
    c_fail_access: cover property (i_power_fail && !ce_n);
endmodule

// ===== rtc_bus_if.sv
`timescale 1ns/1ps
// byte-wide strobe bus, every pin a level
interface rtc_bus_if;
    logic [18:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  dq_host;
    logic        dq_host_oe;
    logic [7:0]  dq_dev;
    logic        dq_dev_oe;
    logic [7:0]  dq;
    // resolved data level
    assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : 8'hff);
    modport dev  (input addr, ce_n, oe_n, we_n, dq, output dq_dev, dq_dev_oe);
    modport host (output addr, ce_n, oe_n, we_n, dq_host, dq_host_oe, input dq);
endinterface

// ===== rtc_dev.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module rtc_dev #(
    parameter int SEC_CYC = rtc_pkg::SEC_DIV
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_power_fail,
    input  wire logic i_battery_good,
    rtc_bus_if.dev    bus
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // bcd helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                      : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
        unique case (mon)
            8'h02:                      month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default:                    month_len = 8'h31;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  cnt_r [8];   // internal counters, index = address low bits
    logic [7:0]  vis_r [8];   // host-visible copy
    logic        whold_r;
    logic        rhold_r;
    logic        osc_halt_r;
    logic        ftest_r;
    logic        ftog_r;
    logic [31:0] sec_div_r;
    logic [31:0] ft_div_r;
    logic        load_r;
    logic        tick;
    logic        hold;
    logic        sel;
    logic        wr_act;
    logic        wr_prev_r;
    logic        wr_start;
    logic [2:0]  idx;
    logic [7:0]  wd;
    logic [18:0] addr_prev_r;
    logic [1:0]  acc_r;

    assign hold     = whold_r | rhold_r;
    assign sel      = (bus.addr[18:3] == ADDR_CTRL[18:3]);
    assign idx      = bus.addr[2:0];
    assign wd       = bus.dq;
    assign wr_act   = !i_power_fail && !bus.ce_n && !bus.we_n;
    assign wr_start = wr_act && !wr_prev_r;
    assign tick     = !osc_halt_r && (sec_div_r == SEC_CYC - 1);

    // ------------------------------------------------------------
    // oscillator dividers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || osc_halt_r) begin
            sec_div_r <= '0;
            ft_div_r  <= '0;
            ftog_r    <= 1'b0;
        end else begin
            sec_div_r <= tick ? '0 : sec_div_r + 32'd1;
            if (ft_div_r == FTEST_DIV - 1) begin
                ft_div_r <= '0;
                ftog_r   <= ~ftog_r;
            end else begin
                ft_div_r <= ft_div_r + 32'd1;
            end
        end
    end

    // write edge detect
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wr_prev_r <= 1'b0;
        end else begin
            wr_prev_r <= wr_act;
        end
    end

    // ------------------------------------------------------------
    // control bits and visible registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            whold_r    <= 1'b0;
            rhold_r    <= 1'b0;
            osc_halt_r <= 1'b0;
            ftest_r    <= 1'b0;
            load_r     <= 1'b0;
            for (int k = 0; k < 8; k++) begin
                vis_r[k] <= RST_ZERO;
            end
        end else begin
            load_r <= 1'b0;
            // refresh all, century too; skipped while counters load the set point
            if (!hold && !load_r) begin
                for (int k = 0; k < 8; k++) begin
                    vis_r[k] <= cnt_r[k];
                end
            end
            if (wr_start && sel) begin
                if (idx == 3'd0) begin
                    whold_r <= wd[BIT_WHOLD];
                    rhold_r <= wd[BIT_RHOLD];
                    if (whold_r && !wd[BIT_WHOLD]) begin
                        vis_r[0] <= wd & MASK_CENT;
                        load_r   <= 1'b1;
                    end
                end else begin
                    if (idx == 3'd1) begin
                        osc_halt_r <= wd[BIT_OSC_HALT];
                    end
                    if (idx == 3'd4) begin
                        ftest_r <= wd[BIT_FTEST]; // battery bit only reaches vis_r[4] under write hold, never read back
                    end
                    if (whold_r) begin
                        vis_r[idx] <= wd;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // internal counters with bcd carry
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cnt_r[0] <= RST_CENT;
            cnt_r[1] <= RST_ZERO;
            cnt_r[2] <= RST_ZERO;
            cnt_r[3] <= RST_ZERO;
            cnt_r[4] <= RST_ONE;
            cnt_r[5] <= RST_ONE;
            cnt_r[6] <= RST_ONE;
            cnt_r[7] <= RST_ZERO;
        end else if (load_r) begin
            for (int k = 0; k < 8; k++) begin
                cnt_r[k] <= vis_r[k];
            end
            cnt_r[1] <= vis_r[1] & MASK_SEC;
            cnt_r[4] <= vis_r[4] & MASK_DAY;
        end else if (wr_start && sel && idx == 3'd0 && !wd[BIT_WHOLD] && whold_r) begin
            cnt_r[0] <= wd & MASK_CENT;
        end else if (tick && !whold_r) begin
            if (cnt_r[1] != 8'h59) begin
                cnt_r[1] <= bcd_inc(cnt_r[1]);
            end else begin
                cnt_r[1] <= 8'h00;
                if (cnt_r[2] != 8'h59) begin
                    cnt_r[2] <= bcd_inc(cnt_r[2]);
                end else begin
                    cnt_r[2] <= 8'h00;
                    if (cnt_r[3] != 8'h23) begin
                        cnt_r[3] <= bcd_inc(cnt_r[3]);
                    end else begin
                        cnt_r[3] <= 8'h00;
                        cnt_r[4] <= (cnt_r[4] == 8'h07) ? 8'h01 : cnt_r[4] + 8'h01;
                        if (cnt_r[5] != month_len(cnt_r[6], cnt_r[7])) begin
                            cnt_r[5] <= bcd_inc(cnt_r[5]);
                        end else begin
                            cnt_r[5] <= 8'h01;
                            if (cnt_r[6] != 8'h12) begin
                                cnt_r[6] <= bcd_inc(cnt_r[6]);
                            end else begin
                                cnt_r[6] <= 8'h01;
                                if (cnt_r[7] != 8'h99) begin
                                    cnt_r[7] <= bcd_inc(cnt_r[7]);
                                end else begin
                                    cnt_r[7] <= 8'h00;
                                    cnt_r[0] <= (cnt_r[0] == 8'h39) ? 8'h00
                                                                    : bcd_inc(cnt_r[0]);
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            addr_prev_r <= '0;
            acc_r       <= '0;
            bus.dq_dev  <= 8'h00;
        end else begin
            addr_prev_r <= bus.addr;
            if (bus.addr != addr_prev_r) begin
                acc_r      <= '0;
                bus.dq_dev <= 8'h00; // indeterminate shown as zero
            end else if (acc_r != 2'(ACC_CYC)) begin
                acc_r <= acc_r + 2'd1;
            end else if (!sel) begin
                bus.dq_dev <= 8'hff; // memory array not modelled
            end else begin
                unique case (idx)
                    3'd0: bus.dq_dev <= {whold_r, rhold_r, vis_r[0][5:0]};
                    3'd1: bus.dq_dev <= {osc_halt_r, vis_r[1][6:1],
                                         ftest_r && !osc_halt_r ? ftog_r : vis_r[1][0]};
                    3'd2: bus.dq_dev <= vis_r[2] & MASK_MIN;
                    3'd3: bus.dq_dev <= vis_r[3] & MASK_HOUR;
                    3'd4: bus.dq_dev <= {i_battery_good, ftest_r, 3'b000,
                                         vis_r[4][2:0]};
                    3'd5: bus.dq_dev <= vis_r[5] & MASK_DATE;
                    3'd6: bus.dq_dev <= vis_r[6] & MASK_MONTH;
                    3'd7: bus.dq_dev <= vis_r[7];
                endcase
            end
        end
    end

    // output drive only for a valid read
    assign bus.dq_dev_oe = !i_power_fail && !bus.ce_n && !bus.oe_n && bus.we_n;
endmodule

// ===== rtc_host.sv
`timescale 1ns/1ps
module rtc_host (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    rtc_bus_if.host          bus
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // apb: word at paddr[4:2] maps to clock register index
    // ------------------------------------------------------------
    rtc_hst_t   st_r;
    logic [2:0] cnt_r;
    logic       busy;

    assign busy     = i_psel && i_penable;
    assign o_pready = (st_r == H_DONE);
    assign o_pslverr = 1'b0;

    // strobe sequencer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_r           <= H_IDLE;
            cnt_r          <= '0;
            bus.addr       <= '0;
            bus.ce_n       <= 1'b1;
            bus.oe_n       <= 1'b1;
            bus.we_n       <= 1'b1;
            bus.dq_host    <= 8'h00;
            bus.dq_host_oe <= 1'b0;
            o_prdata       <= '0;
        end else begin
            unique case (st_r)
                H_IDLE: if (busy) begin
                    bus.addr       <= {ADDR_CTRL[18:3], i_paddr[4:2]}; // stable address
                    bus.dq_host    <= i_pwdata[7:0]; // software supplies bcd, zeros
                    bus.dq_host_oe <= i_pwrite;
                    cnt_r          <= '0;
                    st_r           <= H_SETUP;
                end
                H_SETUP: begin
                    bus.ce_n <= 1'b0;
                    bus.we_n <= !i_pwrite;
                    bus.oe_n <= i_pwrite;
                    st_r     <= H_STROBE;
                end
                H_STROBE: begin
                    cnt_r <= cnt_r + 3'd1;
                    if (cnt_r == 3'(ACC_CYC + 2)) begin
                        o_prdata       <= {24'h0, bus.dq}; // sampled after settling
                        bus.ce_n       <= 1'b1;
                        bus.oe_n       <= 1'b1;
                        bus.we_n       <= 1'b1;
                        st_r           <= H_DONE;
                    end
                end
                H_DONE: begin
                    bus.dq_host_oe <= 1'b0;
                    st_r           <= H_IDLE;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end
endmodule

// ===== rtc_pkg.sv
// Contract
// - registers hold bcd tens and units digits
// - weekday advances at midnight, consecutive values
// - read hold stops visible register updates
// - visible copy frozen, counters keep running
// - refresh within a second after release
// - write hold, load, 00h transfers to counters
// - clearing read hold loads no host values
// - setting a hold keeps century field
// - clearing write hold loads century field
// - clearing read hold keeps century field
// - seconds msb halts the oscillator
// - frequency test toggles seconds lsb 512hz
// - host writes zero to unused bits
// - read when select, output enable low
// - drive data only when select and oe low
// - address change gives brief hold, then indeterminate
// - write when select and write strobe low
// - power fail blocks every access
// - battery flag ignores writes, shows battery
package rtc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 19;
    localparam logic [18:0] ADDR_CTRL    = 19'h7fff8;
    localparam logic [18:0] ADDR_SEC     = 19'h7fff9;
    localparam logic [18:0] ADDR_MIN     = 19'h7fffa;
    localparam logic [18:0] ADDR_HOUR    = 19'h7fffb;
    localparam logic [18:0] ADDR_DAY     = 19'h7fffc;
    localparam logic [18:0] ADDR_DATE    = 19'h7fffd;
    localparam logic [18:0] ADDR_MONTH   = 19'h7fffe;
    localparam logic [18:0] ADDR_YEAR    = 19'h7ffff;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int          BIT_WHOLD    = 7;
    localparam int          BIT_RHOLD    = 6;
    localparam int          BIT_OSC_HALT = 7;
    localparam int          BIT_FTEST    = 6;
    localparam int          BIT_BATT     = 7;
    localparam logic [7:0]  MASK_CENT    = 8'h3f;
    localparam logic [7:0]  MASK_SEC     = 8'h7f;
    localparam logic [7:0]  MASK_MIN     = 8'h7f;
    localparam logic [7:0]  MASK_HOUR    = 8'h3f;
    localparam logic [7:0]  MASK_DAY     = 8'h07;
    localparam logic [7:0]  MASK_DATE    = 8'h3f;
    localparam logic [7:0]  MASK_MONTH   = 8'h1f;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_ZERO     = 8'h00;
    localparam logic [7:0]  RST_ONE      = 8'h01;
    localparam logic [7:0]  RST_CENT     = 8'h20;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ       = 20000000;
    localparam int          FTEST_HZ     = 512;
    localparam int          FTEST_DIV    = CLK_HZ / (2 * FTEST_HZ);
    localparam int          SEC_DIV      = CLK_HZ;
    localparam int          ACC_CYC      = 2;
    localparam int          HOLD_CYC     = 1;
    // ------------------------------------------------------------
    // host states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_DONE} rtc_hst_t;
endpackage

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import rtc_pkg::*;
    localparam int SC = 20; // cycles per second, shortened
    logic        i_clk_sys = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        pf        = 1'b0;
    logic        bg        = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic [7:0]  q;
    logic [7:0]  q1;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          seed = 4194;
    int          r;
    int          nw = 0;
    int          dt[3]  = '{31, 28, 28};
    int          mo[3]  = '{12, 2, 2};
    int          yr[3]  = '{99, 4, 3};
    int          edt[3] = '{1, 29, 1};
    int          emo[3] = '{1, 2, 3};
    int          eyr[3] = '{0, 4, 3};
    int          ecn[3] = '{20, 19, 19};
    int          mdl[8];

    rtc_bus_if u_rtc_bus_if ();
    rtc_dev #(.SEC_CYC(SC)) u_rtc_dev (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_power_fail(pf), .i_battery_good(bg), .bus(u_rtc_bus_if));
    rtc_host u_rtc_host (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(), .bus(u_rtc_bus_if));
    rtc_bus_asserts u_rtc_bus_asserts (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_power_fail(pf), .addr(u_rtc_bus_if.addr), .ce_n(u_rtc_bus_if.ce_n),
        .oe_n(u_rtc_bus_if.oe_n), .we_n(u_rtc_bus_if.we_n),
        .dq_host_oe(u_rtc_bus_if.dq_host_oe), .dq_dev(u_rtc_bus_if.dq_dev),
        .dq_dev_oe(u_rtc_bus_if.dq_dev_oe));

    // clock and hang guard
    always #25 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 30000) begin // covers the frequency test wait
            mismatches++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + (v % 10));
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [2:0] idx, input logic [7:0] d);
        nw = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {7'h00, idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge i_clk_sys);
        penable <= 1'b1;
        @(posedge i_clk_sys);
        while (pready !== 1'b1) begin
            nw++;
            @(posedge i_clk_sys);
        end
        q = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    // hold, load all registers, release with century
    task automatic setclk(input logic [7:0] cn, input logic [7:0] s, input int mi, input int h,
                          input int dy, input int d, input int m, input int y);
        mdl = '{cn, s, mi, h, dy, d, m, y};
        apb(1'b1, 3'd0, 8'h80);
        apb(1'b1, 3'd1, s);
        for (int i = 2; i < 8; i++) apb(1'b1, 3'(i), bcd(mdl[i]));
        apb(1'b1, 3'd0, cn);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        // load, then freeze and release
        r = $unsigned($random(seed)) % 40;
        setclk(8'h19, bcd(r), 7, 12, 3, 15, 6, 24);
        apb(1'b0, 3'd0, 8'h00);
        check(q, 8'h19);
        for (int i = 2; i < 7; i++) begin
            apb(1'b0, 3'(i), 8'h00);
            check(q & 8'h7f, (i == 4) ? 8'h03 : bcd(mdl[i]));
        end
        apb(1'b1, 3'd0, 8'h7f);
        apb(1'b0, 3'd0, 8'h00);
        check(q, 8'h59);
        apb(1'b0, 3'd1, 8'h00);
        q1 = q;
        repeat (3 * SC) @(posedge i_clk_sys);
        apb(1'b0, 3'd1, 8'h00);
        check(q, q1);
        apb(1'b1, 3'd0, 8'h05);
        apb(1'b0, 3'd0, 8'h00);
        check(q, 8'h19);
        repeat (2 * SC) @(posedge i_clk_sys);
        apb(1'b0, 3'd1, 8'h00);
        check((q > q1) ? 8'h01 : 8'h00, 8'h01);
        $display("test 1 done");
        // midnight carries across month, year and leap
        for (int k = 0; k < 3; k++) begin
            setclk(8'h19, 8'h58, 59, 23, 7, dt[k], mo[k], yr[k]);
            repeat (3 * SC) @(posedge i_clk_sys);
            apb(1'b1, 3'd0, 8'h40);
            apb(1'b0, 3'd3, 8'h00);
            check(q, 8'h00);
            apb(1'b0, 3'd4, 8'h00);
            check(q, 8'h81);
            apb(1'b0, 3'd5, 8'h00);
            check(q, bcd(edt[k]));
            apb(1'b0, 3'd6, 8'h00);
            check(q, bcd(emo[k]));
            apb(1'b0, 3'd7, 8'h00);
            check(q, bcd(eyr[k]));
            apb(1'b0, 3'd0, 8'h00);
            check(q, 8'h40 | bcd(ecn[k]));
            apb(1'b1, 3'd0, 8'h00);
        end
        $display("test 2 done");
        // battery flag follows the battery, read with it low then high
        for (int b = 0; b < 2; b++) begin
            bg <= b[0];
            apb(1'b0, 3'd4, 8'h00);
            check({7'h00, q[7]}, {7'h00, b[0]});
        end
        // oscillator halted while loaded
        setclk(8'h19, 8'hb0, 0, 1, 1, 1, 1, 1);
        repeat (3 * SC) @(posedge i_clk_sys);
        apb(1'b0, 3'd1, 8'h00);
        check(q, 8'hb0);
        // oscillator restarted, frequency test on
        apb(1'b1, 3'd1, 8'h00);
        apb(1'b1, 3'd4, 8'h40);
        apb(1'b0, 3'd4, 8'h00);
        check(q, 8'hc1);
        apb(1'b0, 3'd1, 8'h00);
        q1 = q;
        // next sample exactly one divider period later: one toggle
        repeat (FTEST_DIV - nw - 3) @(posedge i_clk_sys);
        apb(1'b0, 3'd1, 8'h00);
        check({7'h00, q[0]}, {7'h00, ~q1[0]});
        $display("test 3 done");
        // power fail blocks reads and writes
        pf <= 1'b1;
        @(posedge i_clk_sys);
        apb(1'b1, 3'd0, 8'h80);
        apb(1'b0, 3'd0, 8'h00);
        check(q, 8'hff);
        pf <= 1'b0;
        @(posedge i_clk_sys);
        apb(1'b0, 3'd0, 8'h00);
        check(q, 8'h19);
        $display("test 4 done");
        report_and_stop();
    end
endmodule
